// ### src/sw_id_pkg.sv
// shared constants, types and crc helpers for the single-wire identity link
package sw_id_pkg;

  // rom-level command bytes
  localparam logic [7:0] CMD_READ_ID = 8'h33;
  localparam logic [7:0] CMD_MATCH_ID = 8'h55;
  localparam logic [7:0] CMD_SEARCH_ID = 8'hF0;
  localparam logic [7:0] CMD_SKIP_ID = 8'hCC;
  localparam logic [7:0] CMD_FAST_SKIP = 8'h3C;
  localparam logic [7:0] CMD_FAST_MATCH = 8'h69;

  // identity layout
  localparam int ID_BITS = 64;
  localparam int SERIAL_BITS = 48;
  localparam int ID_BODY_BITS = 56;
  localparam logic [5:0] ID_LAST_BIT = 6'h3F;
  localparam logic [2:0] BYTE_LAST_BIT = 3'h7;

  // crc tap pattern after right shift: x^8 + x^5 + x^4 + 1
  localparam logic [7:0] CRC_TAPS = 8'h8C;
  localparam logic [7:0] CRC_INIT = 8'h00;

  // data store sizes
  localparam int SCRATCH_BYTES = 32;
  localparam int MAIN_BYTES = 8192;
  localparam int STORE_AW = 13;

  // slot pacing in mclk cycles (regular and high speed)
  localparam logic [7:0] SLOT_REG_CYC = 8'h40;
  localparam logic [7:0] SLOT_FAST_CYC = 8'h08;

  // reset values
  localparam logic SPEED_RESET = 1'b0;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // host operations
  typedef enum logic [1:0] {
    OP_RESET,
    OP_WRITE,
    OP_READ
  } host_op_e;

  // one crc step, feedback applied at the taps
  function automatic logic [7:0] crc8_step(input logic [7:0] crc, input logic bit_in);
    logic fb;
    fb = bit_in ^ crc[0];
    crc8_step = fb ? ((crc >> 1) ^ CRC_TAPS) : (crc >> 1);
  endfunction

  // crc over family code and serial number, lsb first
  function automatic logic [7:0] crc8_body(input logic [55:0] body);
    logic [7:0] crc;
    crc = CRC_INIT;
    for (int i = 0; i < ID_BODY_BITS; i++) begin
      crc = crc8_step(crc, body[i]);
    end
    crc8_body = crc;
  endfunction

endpackage

// ### src/sw_link_if.sv
// abstract single-wire link: reset strobes and bit slots, wired-and data
interface sw_link_if;
  logic rst_stb;    // line reset pulse from master
  logic rst_fast;   // reset sent with high-speed timing
  logic slot_stb;   // one bit slot, one cycle
  logic master_bit; // master level in slot, 1 for read slots
  logic dev_bit;    // device level, 1 = released
  logic line_bit;   // resolved line level

  // open-drain line: either party pulls low
  assign line_bit = master_bit & dev_bit;

  modport master (output rst_stb, output rst_fast, output slot_stb, output master_bit, input line_bit);
  modport device (input rst_stb, input rst_fast, input slot_stb, input line_bit, output dev_bit);
endinterface

// ### src/sw_id_device.sv
// device end: identity code, rom command layer, speed flag and data stores
module sw_id_device #(
  parameter logic [7:0] FAMILY_CODE = 8'h5A,           // arbitrary value
  parameter logic [47:0] SERIAL_NUM = 48'h0123456789AB  // arbitrary value
) (
  input wire logic mclk,                           // system clock
  input wire logic reset_n,                        // async reset, active low
  sw_link_if.device link,                          // line side
  output logic speed_select_flag,                  // high-speed mode active
  output logic mem_access_q,                       // memory commands open
  output logic mem_cmd_valid_q,                    // memory command byte pulse
  output logic [7:0] mem_cmd_q,                    // memory command byte
  input wire logic store_we,                       // user store write
  input wire logic store_sel,                      // 0 main array, 1 scratchpad
  input wire logic [sw_id_pkg::STORE_AW-1:0] store_addr, // byte address
  input wire logic [7:0] store_wdata,              // write byte
  output logic [7:0] store_rdata_q                 // read byte, next cycle
);
  import sw_id_pkg::*;

  typedef enum logic [2:0] {
    DV_ROM_CMD,
    DV_ID_TX,
    DV_ID_MATCH,
    DV_SEARCH,
    DV_MEM_CMD,
    DV_MEM_BODY,
    DV_IDLE
  } dev_state_e;

  // identity: check byte, serial, family from msb down
  localparam logic [63:0] ID_CODE = {crc8_body({SERIAL_NUM, FAMILY_CODE}), SERIAL_NUM, FAMILY_CODE};

  dev_state_e st_q, st_d;
  logic [5:0] cnt_q, cnt_d;
  logic [1:0] ph_q, ph_d;
  logic [7:0] sh_q;
  logic [7:0] byte_in;
  logic speed_q;
  logic dev_bit_q, dev_bit_d;
  logic lv;
  logic id_bit;
  logic [7:0] scratch_mem [0:SCRATCH_BYTES-1];
  logic [7:0] main_mem [0:MAIN_BYTES-1];

  assign lv = link.line_bit;
  assign id_bit = ID_CODE[cnt_q];
  // lsb arrives first, so new bit enters at the top
  assign byte_in = {lv, sh_q[7:1]};
  assign speed_select_flag = speed_q;
  assign link.dev_bit = dev_bit_q;

  // next protocol state on each slot
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    ph_d = ph_q;
    if (link.rst_stb) begin
      st_d = DV_ROM_CMD;
      cnt_d = 6'h00;
      ph_d = 2'h0;
    end else if (link.slot_stb) begin
      unique case (st_q)
        DV_ROM_CMD: begin
          cnt_d = cnt_q + 6'h01;
          if (cnt_q[2:0] == BYTE_LAST_BIT) begin
            cnt_d = 6'h00;
            unique case (byte_in)
              CMD_READ_ID: st_d = DV_ID_TX;
              CMD_MATCH_ID, CMD_FAST_MATCH: st_d = DV_ID_MATCH;
              CMD_SEARCH_ID: st_d = DV_SEARCH;
              CMD_SKIP_ID, CMD_FAST_SKIP: st_d = DV_MEM_CMD;
              default: st_d = DV_IDLE;
            endcase
          end
        end
        DV_ID_TX: begin
          cnt_d = cnt_q + 6'h01;
          if (cnt_q == ID_LAST_BIT) begin
            st_d = DV_MEM_CMD;
          end
        end
        DV_ID_MATCH: begin
          cnt_d = cnt_q + 6'h01;
          if (lv != id_bit) begin
            st_d = DV_IDLE;
          end else if (cnt_q == ID_LAST_BIT) begin
            st_d = DV_MEM_CMD;
          end
        end
        DV_SEARCH: begin
          // bit, complement, then master direction
          ph_d = ph_q + 2'h1;
          if (ph_q == 2'h2) begin
            ph_d = 2'h0;
            cnt_d = cnt_q + 6'h01;
            if (lv != id_bit) begin
              st_d = DV_IDLE;
            end else if (cnt_q == ID_LAST_BIT) begin
              st_d = DV_MEM_CMD;
            end
          end
        end
        DV_MEM_CMD: begin
          cnt_d = cnt_q + 6'h01;
          if (cnt_q[2:0] == BYTE_LAST_BIT) begin
            cnt_d = 6'h00;
            st_d = DV_MEM_BODY;
          end
        end
        DV_MEM_BODY: st_d = DV_MEM_BODY;
        DV_IDLE: st_d = DV_IDLE;
      endcase
    end
  end

  // device read level for the next slot
  always_comb begin
    dev_bit_d = 1'b1;
    if (st_d == DV_ID_TX) begin
      dev_bit_d = ID_CODE[cnt_d];
    end else if (st_d == DV_SEARCH) begin
      if (ph_d == 2'h0) begin
        dev_bit_d = ID_CODE[cnt_d];
      end else if (ph_d == 2'h1) begin
        dev_bit_d = ~ID_CODE[cnt_d];
      end
    end
  end

  // protocol state registers
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= DV_ROM_CMD;
      cnt_q <= 6'h00;
      ph_q <= 2'h0;
      dev_bit_q <= 1'b1;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      ph_q <= ph_d;
      dev_bit_q <= dev_bit_d;
    end
  end

  // command byte shifter, lsb first
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sh_q <= BYTE_RESET;
    end else if (link.rst_stb) begin
      sh_q <= BYTE_RESET;
    end else if (link.slot_stb && (st_q == DV_ROM_CMD || st_q == DV_MEM_CMD)) begin
      sh_q <= byte_in;
    end
  end

  // speed flag: regular by default, fast after high-speed command
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      speed_q <= SPEED_RESET;
    end else if (link.rst_stb) begin
      if (!link.rst_fast) begin
        speed_q <= 1'b0;
      end
    end else if (link.slot_stb && st_q == DV_ROM_CMD && cnt_q[2:0] == BYTE_LAST_BIT && !speed_q
                 && (byte_in == CMD_FAST_SKIP || byte_in == CMD_FAST_MATCH)) begin
      speed_q <= 1'b1;
    end
  end

  // memory command gate: only after a finished rom command
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mem_access_q <= 1'b0;
      mem_cmd_valid_q <= 1'b0;
      mem_cmd_q <= BYTE_RESET;
    end else begin
      mem_access_q <= (st_d == DV_MEM_CMD) || (st_d == DV_MEM_BODY);
      mem_cmd_valid_q <= 1'b0;
      if (link.slot_stb && !link.rst_stb && st_q == DV_MEM_CMD && cnt_q[2:0] == BYTE_LAST_BIT) begin
        mem_cmd_valid_q <= 1'b1;
        mem_cmd_q <= byte_in;
      end
    end
  end

  // scratchpad and main array, user port
  always_ff @(posedge mclk) begin
    if (store_we) begin
      if (store_sel) begin
        scratch_mem[store_addr[4:0]] <= store_wdata;
      end else begin
        main_mem[store_addr] <= store_wdata;
      end
    end
  end

  // registered store read
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      store_rdata_q <= BYTE_RESET;
    end else if (store_sel) begin
      store_rdata_q <= scratch_mem[store_addr[4:0]];
    end else begin
      store_rdata_q <= main_mem[store_addr];
    end
  end

endmodule

// ### src/sw_id_host.sv
// master end: reset and byte transfers with slot pacing and crc check
module sw_id_host (
  input wire logic mclk,                    // system clock
  input wire logic reset_n,                 // async reset, active low
  sw_link_if.master link,                   // line side
  input wire logic op_valid,                // operation request
  input wire sw_id_pkg::host_op_e op_code,  // reset, write or read
  input wire logic [7:0] op_wdata,          // byte to write
  input wire logic op_regular,              // reset at regular timing
  output logic op_ready,                    // ready for a request
  output logic done_q,                      // operation finished pulse
  output logic [7:0] rd_data_q,             // resolved line byte of the last transfer, read or write
  output logic [7:0] crc_residue_q,         // crc since last reset or write
  output logic speed_select_flag            // host link speed
);
  import sw_id_pkg::*;

  typedef enum logic [1:0] {
    HS_IDLE,
    HS_RESET,
    HS_BITS
  } host_state_e;

  host_state_e st_q;
  logic [7:0] div_q;
  logic tick;
  logic [7:0] sh_q;
  logic [2:0] bit_q;
  logic is_read_q;
  logic first_q;
  logic speed_q;
  logic rst_stb_q, rst_fast_q, slot_stb_q, mbit_q;
  logic [7:0] byte_in;

  assign op_ready = (st_q == HS_IDLE);
  assign tick = (div_q == 8'h00);
  assign speed_select_flag = speed_q;
  assign link.rst_stb = rst_stb_q;
  assign link.rst_fast = rst_fast_q;
  assign link.slot_stb = slot_stb_q;
  assign link.master_bit = mbit_q;
  assign byte_in = {link.line_bit, sh_q[7:1]};

  // slot divider, rate follows speed flag
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      div_q <= SLOT_REG_CYC;
    end else if (tick || st_q == HS_IDLE) begin
      div_q <= speed_q ? SLOT_FAST_CYC : SLOT_REG_CYC;
    end else begin
      div_q <= div_q - 8'h01;
    end
  end

  // operation sequencer
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= HS_IDLE;
      sh_q <= BYTE_RESET;
      bit_q <= 3'h0;
      is_read_q <= 1'b0;
      rst_stb_q <= 1'b0;
      rst_fast_q <= 1'b0;
      slot_stb_q <= 1'b0;
      mbit_q <= 1'b1;
      done_q <= 1'b0;
      rd_data_q <= BYTE_RESET;
    end else begin
      rst_stb_q <= 1'b0;
      slot_stb_q <= 1'b0;
      done_q <= 1'b0;
      unique case (st_q)
        HS_IDLE: begin
          if (op_valid) begin
            bit_q <= 3'h0;
            is_read_q <= (op_code == OP_READ);
            sh_q <= (op_code == OP_READ) ? 8'hFF : op_wdata;
            mbit_q <= (op_code == OP_READ) ? 1'b1 : op_wdata[0];
            rst_fast_q <= speed_q && !op_regular;
            st_q <= (op_code == OP_RESET) ? HS_RESET : HS_BITS;
          end
        end
        HS_RESET: begin
          if (tick) begin
            rst_stb_q <= 1'b1;
            done_q <= 1'b1;
            st_q <= HS_IDLE;
          end
        end
        HS_BITS: begin
          if (tick) begin
            slot_stb_q <= 1'b1;
          end
          if (slot_stb_q) begin
            // shift in resolved level, present next bit lsb first
            sh_q <= byte_in;
            mbit_q <= is_read_q ? 1'b1 : sh_q[1];
            bit_q <= bit_q + 3'h1;
            if (bit_q == BYTE_LAST_BIT) begin
              rd_data_q <= byte_in;
              mbit_q <= 1'b1;
              done_q <= 1'b1;
              st_q <= HS_IDLE;
            end
          end
        end
        default: st_q <= HS_IDLE;
      endcase
    end
  end

  // receiver crc over read bits, zero for a good identity
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      crc_residue_q <= CRC_INIT;
    end else if (st_q == HS_IDLE && op_valid && op_code != OP_READ) begin
      crc_residue_q <= CRC_INIT;
    end else if (st_q == HS_BITS && slot_stb_q && is_read_q) begin
      crc_residue_q <= crc8_step(crc_residue_q, link.line_bit);
    end
  end

  // first byte after reset is the rom command; fast ones raise speed
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      first_q <= 1'b0;
      speed_q <= SPEED_RESET;
    end else if (rst_stb_q) begin
      first_q <= 1'b1;
      if (!rst_fast_q) begin
        speed_q <= 1'b0;
      end
    end else if (st_q == HS_BITS && slot_stb_q && bit_q == BYTE_LAST_BIT) begin
      first_q <= 1'b0;
      if (first_q && !is_read_q && !speed_q && (byte_in == CMD_FAST_SKIP || byte_in == CMD_FAST_MATCH)) begin
        speed_q <= 1'b1;
      end
    end
  end

endmodule

// ### testbench/sw_link_checker.sv
// link checks between host and device ends
module sw_link_checker #(
  parameter logic [7:0] FAMILY_CODE = 8'h00, // arbitrary value
  parameter logic [47:0] SERIAL_NUM = 48'h0  // arbitrary value
) (
  input wire logic mclk,       // clock
  input wire logic reset_n,    // async reset
  input wire logic rst_stb,    // line reset
  input wire logic rst_fast,   // fast reset
  input wire logic slot_stb,   // bit slot
  input wire logic master_bit, // master level
  input wire logic dev_bit,    // device level
  input wire logic line_bit    // wired-and line
);
  timeunit 1ns;
  timeprecision 100ps;
  import sw_id_pkg::*;
  localparam logic [55:0] ID_BODY = {SERIAL_NUM, FAMILY_CODE};
  logic [6:0] cnt_q;
  logic [7:0] cmd_q;
  logic [7:0] crc_q;
  logic [7:0] gap_q;
  logic fast_q;
  logic fb;

  // slots since line reset
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) cnt_q <= 7'h00;
    else if (rst_stb) cnt_q <= 7'h00;
    else if (slot_stb && cnt_q != 7'h7F) cnt_q <= cnt_q + 7'h01;
  end
  // rom command byte, lsb first
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) cmd_q <= 8'h00;
    else if (rst_stb) cmd_q <= 8'h00;
    else if (slot_stb && cnt_q < 7'h08) cmd_q[cnt_q[2:0]] <= line_bit;
  end
  // crc over the 64 identity bits
  assign fb = line_bit ^ crc_q[0];
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) crc_q <= 8'h00;
    else if (rst_stb) crc_q <= 8'h00;
    else if (slot_stb && cnt_q >= 7'h08 && cnt_q < 7'h48) crc_q <= (crc_q >> 1) ^ (fb ? 8'h8C : 8'h00);
  end
  // cycles since last strobe
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) gap_q <= 8'h00;
    else if (rst_stb || slot_stb) gap_q <= 8'h00;
    else if (gap_q != 8'hFF) gap_q <= gap_q + 8'h01;
  end
  // speed as commanded on the line
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) fast_q <= 1'b0;
    else if (rst_stb && !rst_fast) fast_q <= 1'b0;
    else if (slot_stb && cnt_q == 7'h07 && ({line_bit, cmd_q[6:0]} == CMD_FAST_SKIP ||
             {line_bit, cmd_q[6:0]} == CMD_FAST_MATCH)) fast_q <= 1'b1;
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sequence s_id_body_slot;
    slot_stb && cmd_q == CMD_READ_ID && cnt_q >= 7'h08 && cnt_q < 7'h40;
  endsequence
  sequence s_id_complete;
    cnt_q == 7'h48 && cmd_q == CMD_READ_ID;
  endsequence

  a_strobes_apart: assert property (!(rst_stb && slot_stb))
    else $error("reset and slot together");
  a_reset_releases: assert property (rst_stb |=> dev_bit)
    else $error("line held after reset");
  a_rom_byte_quiet: assert property (cnt_q < 7'h08 |-> dev_bit)
    else $error("device drives during rom byte");
  a_id_lsb_first: assert property (s_id_body_slot |-> line_bit == ID_BODY[cnt_q - 7'h08])
    else $error("identity bit wrong");
  a_crc_residue_zero: assert property (s_id_complete |-> crc_q == 8'h00)
    else $error("identity crc residue not zero");
  a_other_cmd_released: assert property (cnt_q >= 7'h08 && cmd_q != CMD_READ_ID
    && cmd_q != CMD_SEARCH_ID |-> dev_bit)
    else $error("device drives outside read");
  a_regular_pacing: assert property (slot_stb && !fast_q |-> gap_q >= 8'h3F)
    else $error("fast slot at regular speed");
  a_fast_reset_kept: assert property (rst_stb && rst_fast |-> fast_q)
    else $error("fast reset while regular");
  a_dev_bit_holds: assert property (!$past(slot_stb) && !$past(rst_stb) |-> $stable(dev_bit))
    else $error("device level moved between slots");
  a_read_released: assert property (s_id_body_slot |-> master_bit)
    else $error("master drives during identity read");
endmodule

// ### testbench/tb.sv
// self-checking bench: host and device over the link
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import sw_id_pkg::*;
  localparam logic [7:0] FAM = 8'hA7;          // arbitrary value
  localparam logic [47:0] SER = 48'h9E3B5C21D4F6; // arbitrary value
  localparam int LIMIT = 40000;
  logic mclk, reset_n, op_valid, op_regular, op_ready, done_q;
  logic store_we, store_sel, dev_speed, host_speed, mem_access_q, mem_cmd_valid_q;
  host_op_e op_code;
  logic [7:0] op_wdata, rd_data_q, crc_residue_q, store_wdata, store_rdata_q, mem_cmd_q;
  logic [12:0] store_addr;
  logic [7:0] id_bytes [8];
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;

  sw_link_if link ();
  sw_id_device #(.FAMILY_CODE(FAM), .SERIAL_NUM(SER)) u_sw_id_device (.mclk(mclk), .reset_n(reset_n),
    .link(link), .speed_select_flag(dev_speed), .mem_access_q(mem_access_q), .mem_cmd_valid_q(mem_cmd_valid_q),
    .mem_cmd_q(mem_cmd_q), .store_we(store_we), .store_sel(store_sel), .store_addr(store_addr),
    .store_wdata(store_wdata), .store_rdata_q(store_rdata_q));
  sw_id_host u_sw_id_host (.mclk(mclk), .reset_n(reset_n), .link(link), .op_valid(op_valid),
    .op_code(op_code), .op_wdata(op_wdata), .op_regular(op_regular), .op_ready(op_ready),
    .done_q(done_q), .rd_data_q(rd_data_q), .crc_residue_q(crc_residue_q),
    .speed_select_flag(host_speed));
  sw_link_checker #(.FAMILY_CODE(FAM), .SERIAL_NUM(SER)) u_sw_link_checker (.mclk(mclk),
    .reset_n(reset_n), .rst_stb(link.rst_stb), .rst_fast(link.rst_fast), .slot_stb(link.slot_stb),
    .master_bit(link.master_bit), .dev_bit(link.dev_bit), .line_bit(link.line_bit));

  // reference crc, lsb first
  function automatic logic [7:0] crc_ref(input logic [55:0] body);
    logic [7:0] c;
    logic f;
    c = 8'h00;
    for (int i = 0; i < 56; i++) begin
      f = body[i] ^ c[0];
      c = {1'b0, c[7:1]};
      if (f) c = c ^ 8'h8C;
    end
    return c;
  endfunction

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_flag(input logic got, input logic exp);
    check_byte({7'h00, got}, {7'h00, exp});
  endtask

  // one host operation, waits for completion
  task automatic host_op(input host_op_e op, input logic [7:0] data, input logic regular);
    int n;
    @(posedge mclk);
    #1;
    op_valid = 1'b1;
    op_code = op;
    op_wdata = data;
    op_regular = regular;
    @(posedge mclk);
    #1;
    op_valid = 1'b0;
    check_flag(op_ready, 1'b0);
    n = 0;
    while (done_q !== 1'b1 && n < 2000) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n == 2000) begin
      err_total++;
      wrap_up();
    end
    // a line reset strobes with done; the device registers act on it one cycle later
    if (op == OP_RESET) begin
      @(posedge mclk);
      #1;
    end
  endtask

  task automatic send_id();
    for (int i = 0; i < 8; i++) host_op(OP_WRITE, id_bytes[i], 1'b1);
  endtask

  // search: two read slots and a direction slot per identity bit
  task automatic search_id();
    logic [191:0] tx;
    logic [191:0] rx;
    logic b;
    for (int i = 0; i < 64; i++) begin
      b = id_bytes[i/8][i%8];
      tx[3*i +: 3] = {b, 2'h3};
      rx[3*i +: 3] = {b, ~b, b};
    end
    for (int k = 0; k < 24; k++) begin
      host_op(OP_WRITE, tx[8*k +: 8], 1'b1);
      check_byte(rd_data_q, rx[8*k +: 8]);
    end
  endtask

  // store write (optional) then read back
  task automatic store_rw(input logic sel, input logic [12:0] addr, input logic [7:0] data, input logic wr);
    store_sel = sel;
    store_addr = addr;
    store_wdata = data;
    store_we = wr;
    @(posedge mclk);
    #1;
    store_we = 1'b0;
    @(posedge mclk);
    #1;
    check_byte(store_rdata_q, data);
  endtask

  task automatic wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // hang guard
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_total++;
      wrap_up();
    end
  end

  initial begin
    reset_n = 1'b0;
    op_valid = 1'b0;
    op_code = OP_RESET;
    op_wdata = 8'h00;
    op_regular = 1'b1;
    store_we = 1'b0;
    store_sel = 1'b0;
    store_addr = 13'h0000;
    store_wdata = 8'h00;
    id_bytes[0] = FAM;
    for (int i = 0; i < 6; i++) id_bytes[i+1] = SER[8*i +: 8];
    id_bytes[7] = crc_ref({SER, FAM});
    repeat (6) @(posedge mclk);
    #1;
    reset_n = 1'b1;
    check_flag(dev_speed, 1'b0);
    check_flag(host_speed, 1'b0);
    // memory byte with no rom command
    host_op(OP_RESET, 8'h00, 1'b1);
    host_op(OP_WRITE, 8'h0F, 1'b1);
    check_flag(mem_access_q, 1'b0);
    check_flag(mem_cmd_valid_q, 1'b0);
    // skip, memory byte, reset closes access
    host_op(OP_RESET, 8'h00, 1'b1);
    host_op(OP_WRITE, CMD_SKIP_ID, 1'b1);
    check_flag(mem_access_q, 1'b1);
    host_op(OP_WRITE, 8'hAA, 1'b1);
    check_flag(mem_cmd_valid_q, 1'b1);
    check_byte(mem_cmd_q, 8'hAA);
    host_op(OP_RESET, 8'h00, 1'b1);
    check_flag(mem_access_q, 1'b0);
    // read the identity code
    host_op(OP_WRITE, CMD_READ_ID, 1'b1);
    for (int i = 0; i < 8; i++) begin
      host_op(OP_READ, 8'hFF, 1'b1);
      check_byte(rd_data_q, id_bytes[i]);
      if (i == 6) check_byte(crc_residue_q, id_bytes[7]);
    end
    check_byte(crc_residue_q, 8'h00);
    check_flag(mem_access_q, 1'b1);
    // search walk, then memory commands open
    host_op(OP_RESET, 8'h00, 1'b1);
    host_op(OP_WRITE, CMD_SEARCH_ID, 1'b1);
    search_id();
    check_flag(mem_access_q, 1'b1);
    // fast skip, fast reset keeps speed
    host_op(OP_RESET, 8'h00, 1'b1);
    host_op(OP_WRITE, CMD_FAST_SKIP, 1'b1);
    check_flag(dev_speed, 1'b1);
    check_flag(host_speed, 1'b1);
    host_op(OP_RESET, 8'h00, 1'b0);
    check_flag(dev_speed, 1'b1);
    check_flag(mem_access_q, 1'b0);
    host_op(OP_WRITE, CMD_MATCH_ID, 1'b1);
    send_id();
    check_flag(mem_access_q, 1'b1);
    host_op(OP_RESET, 8'h00, 1'b1);
    check_flag(dev_speed, 1'b0);
    check_flag(host_speed, 1'b0);
    // fast match at regular speed
    host_op(OP_WRITE, CMD_FAST_MATCH, 1'b1);
    send_id();
    check_flag(dev_speed, 1'b1);
    check_flag(mem_access_q, 1'b1);
    host_op(OP_RESET, 8'h00, 1'b1);
    // top of both stores, no aliasing
    store_rw(1'b0, 13'h1FFF, 8'h5C, 1'b1);
    store_rw(1'b1, 13'h001F, 8'hE3, 1'b1);
    store_rw(1'b0, 13'h1FFF, 8'h5C, 1'b0);
    wrap_up();
  end
endmodule
